// ---- logic/mac_tx_pkg.sv ----
// Constants, types and the frame check function of the transmit frame assembler.
// Assumes one core clock; the host writes frames to buffer memory and the memory read
// side presents them as a byte stream, control byte first.
//
// Summary of operation
// - Device sends preamble and delimiter itself
// - Device pads and appends check sequence when configured
// - One control byte precedes every queued frame
// - Override bit clear selects global configuration
// - Oversize bit clear aborts frame at maximum length
// - Pad bit pads short frame to 60
// - Check bit set appends computed check sequence
// - Check bit clear verifies last four bytes
// - Global append off checks and reports last four
// - Global oversize off aborts over-length frames
// - Request bit starts; device clears, raises done
`default_nettype none

package mac_tx_pkg;

  // ****************************************
  // Control byte layout
  // ****************************************
  localparam int CTRL_OVERRIDE = 0;
  localparam int CTRL_FCS = 1;
  localparam int CTRL_PAD = 2;
  localparam int CTRL_OVERSIZE = 3;

  // Global pad select: bit 0 enables padding, bit 1 picks the long target
  localparam int PADSEL_ON = 0;
  localparam int PADSEL_LONG = 1;

  // ****************************************
  // Frame constants
  // ****************************************
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [2:0] PREAMBLE_LAST = 3'h6;
  localparam logic [2:0] FCS_LAST = 3'h3;
  localparam logic [6:0] PAD_NONE = 7'h00;
  localparam logic [6:0] PAD_SHORT = 7'h3C;
  localparam logic [6:0] PAD_LONG = 7'h40;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // ****************************************
  // Output buffer entry: {abort, last, data}
  // ****************************************
  localparam int BUF_WIDTH = 10;
  localparam int BUF_LAST = 8;
  localparam int BUF_ABORT = 9;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CTRL, ST_PREAMBLE, ST_SFD, ST_DATA, ST_PAD, ST_FCS, ST_ABORT,
    ST_FLUSH, ST_DONE
  } state_t;

  // Reflected CRC-32 update by one byte
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

endpackage : mac_tx_pkg

`default_nettype wire

// ---- logic/tx_byte_buffer.sv ----
// Two-entry buffer between the frame assembler and the wire serialiser.
// Assumes both sides on the same clock; a stall on the output loses no entry.
`default_nettype none

module tx_byte_buffer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [mac_tx_pkg::BUF_WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [mac_tx_pkg::BUF_WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [mac_tx_pkg::BUF_WIDTH-1:0] mem [2];
  logic [mac_tx_pkg::BUF_WIDTH-1:0] next_mem [2];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] fill, next_fill;
  logic do_wr, do_rd;

  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill = fill;
    if (do_wr) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = !wr_ptr;
    end
    if (do_rd) begin
      next_rd_ptr = !rd_ptr;
    end
    if (do_wr && !do_rd) begin
      next_fill = fill + 2'h1;
    end else if (do_rd && !do_wr) begin
      next_fill = fill - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

endmodule : tx_byte_buffer

`default_nettype wire

// ---- logic/mac_tx_frame_assembly.sv ----
// Transmit frame assembler: reads control byte and frame from buffer memory,
// emits preamble, delimiter, frame, padding and check sequence to the serialiser.
// Assumes the memory side presents the frame as a byte stream ending in SRC_LAST.
`default_nettype none

module mac_tx_frame_assembly (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Host request and completion
  input wire logic TX_REQUEST_SET,
  input wire logic TX_CANCEL,
  output logic TX_REQUEST,
  output logic TX_DONE_FLAG,
  input wire logic TX_DONE_CLEAR,
  // Global configuration
  input wire logic GLOBAL_FCS_APPEND,
  input wire logic GLOBAL_OVERSIZE_ALLOW,
  input wire logic [2:0] GLOBAL_PAD_SELECT,
  input wire logic [15:0] MAX_FRAME_LENGTH,
  // Byte stream from buffer memory
  input wire logic SRC_VALID,
  input wire logic [7:0] SRC_DATA,
  input wire logic SRC_LAST,
  output logic SRC_READY,
  // Byte stream to the wire serialiser
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic TX_ABORT,
  input wire logic TX_READY,
  // Status of the last packet
  output logic TX_ABORTED,
  output logic TX_GIANT,
  output logic TX_FCS_ERROR,
  output logic [15:0] TX_BYTE_COUNT
);

  // ****************************************
  // State
  // ****************************************
  mac_tx_pkg::state_t state, next_state;
  logic [31:0] crc, next_crc;
  logic [15:0] count, next_count;
  logic [2:0] step, next_step;
  logic src_done, next_src_done;
  logic opt_fcs, next_opt_fcs;
  logic opt_oversize, next_opt_oversize;
  logic [6:0] opt_pad_len, next_opt_pad_len;
  logic aborted, next_aborted;
  logic giant, next_giant;
  logic fcs_error, next_fcs_error;
  logic [15:0] byte_count, next_byte_count;
  logic req, next_req;
  logic done_flag, next_done_flag;

  logic push;
  logic [mac_tx_pkg::BUF_WIDTH-1:0] push_data;
  logic buf_ready;
  logic finish;
  logic over_limit;
  logic pad_more;
  logic [15:0] count_inc;
  logic [mac_tx_pkg::BUF_WIDTH-1:0] buf_out;

  assign count_inc = count + 16'h0001;
  assign pad_more = count_inc < {9'h000, opt_pad_len};
  assign over_limit = !opt_oversize && (count >= MAX_FRAME_LENGTH);

  // ****************************************
  // Frame sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_crc = crc;
    next_count = count;
    next_step = step;
    next_src_done = src_done;
    next_opt_fcs = opt_fcs;
    next_opt_oversize = opt_oversize;
    next_opt_pad_len = opt_pad_len;
    next_aborted = aborted;
    next_giant = giant;
    next_fcs_error = fcs_error;
    next_byte_count = byte_count;
    push = 1'b0;
    push_data = '0;
    SRC_READY = 1'b0;
    finish = 1'b0;
    case (state)
      mac_tx_pkg::ST_IDLE: begin
        if (req) begin
          next_state = mac_tx_pkg::ST_CTRL;
          next_crc = mac_tx_pkg::CRC_INIT;
          next_count = 16'h0000;
          next_step = 3'h0;
          next_src_done = 1'b0;
          next_aborted = 1'b0;
          next_giant = 1'b0;
          next_fcs_error = 1'b0;
        end
      end
      mac_tx_pkg::ST_CTRL: begin
        SRC_READY = 1'b1;
        if (SRC_VALID) begin
          if (SRC_DATA[mac_tx_pkg::CTRL_OVERRIDE]) begin
            next_opt_fcs = SRC_DATA[mac_tx_pkg::CTRL_FCS];
            next_opt_oversize = SRC_DATA[mac_tx_pkg::CTRL_OVERSIZE];
            next_opt_pad_len = SRC_DATA[mac_tx_pkg::CTRL_PAD] ? mac_tx_pkg::PAD_SHORT
                                                                 : mac_tx_pkg::PAD_NONE;
          end else begin
            next_opt_fcs = GLOBAL_FCS_APPEND;
            next_opt_oversize = GLOBAL_OVERSIZE_ALLOW;
            if (!GLOBAL_PAD_SELECT[mac_tx_pkg::PADSEL_ON]) begin
              next_opt_pad_len = mac_tx_pkg::PAD_NONE;
            end else if (GLOBAL_PAD_SELECT[mac_tx_pkg::PADSEL_LONG]) begin
              next_opt_pad_len = mac_tx_pkg::PAD_LONG;
            end else begin
              next_opt_pad_len = mac_tx_pkg::PAD_SHORT;
            end
          end
          if (SRC_LAST) begin
            next_src_done = 1'b1;
            next_state = mac_tx_pkg::ST_ABORT;
          end else begin
            next_state = mac_tx_pkg::ST_PREAMBLE;
          end
        end
      end
      mac_tx_pkg::ST_PREAMBLE: begin
        push = 1'b1;
        push_data = {2'b00, mac_tx_pkg::PREAMBLE_BYTE};
        if (buf_ready) begin
          next_step = step + 3'h1;
          if (step == mac_tx_pkg::PREAMBLE_LAST) begin
            next_step = 3'h0;
            next_state = mac_tx_pkg::ST_SFD;
          end
        end
      end
      mac_tx_pkg::ST_SFD: begin
        push = 1'b1;
        push_data = {2'b00, mac_tx_pkg::SFD_BYTE};
        if (buf_ready) begin
          next_state = mac_tx_pkg::ST_DATA;
        end
      end
      mac_tx_pkg::ST_DATA: begin
        if (SRC_VALID && over_limit) begin
          next_giant = 1'b1;
          next_state = mac_tx_pkg::ST_ABORT;
        end else begin
          SRC_READY = buf_ready;
          push = SRC_VALID;
          push_data = {1'b0, SRC_LAST && !pad_more && !opt_fcs, SRC_DATA};
          if (SRC_VALID && buf_ready) begin
            next_crc = mac_tx_pkg::crc_step(crc, SRC_DATA);
            next_count = count_inc;
            if (SRC_LAST) begin
              next_src_done = 1'b1;
              if (pad_more) begin
                next_state = mac_tx_pkg::ST_PAD;
              end else if (opt_fcs) begin
                next_state = mac_tx_pkg::ST_FCS;
              end else begin
                next_state = mac_tx_pkg::ST_DONE;
              end
            end
          end
        end
      end
      mac_tx_pkg::ST_PAD: begin
        push = 1'b1;
        push_data = {1'b0, !pad_more && !opt_fcs, mac_tx_pkg::PAD_BYTE};
        if (buf_ready) begin
          next_crc = mac_tx_pkg::crc_step(crc, mac_tx_pkg::PAD_BYTE);
          next_count = count_inc;
          if (!pad_more) begin
            next_state = opt_fcs ? mac_tx_pkg::ST_FCS : mac_tx_pkg::ST_DONE;
          end
        end
      end
      mac_tx_pkg::ST_FCS: begin
        push = 1'b1;
        push_data = {1'b0, step == mac_tx_pkg::FCS_LAST, ~crc[8*step[1:0] +: 8]};
        if (buf_ready) begin
          next_count = count_inc;
          next_step = step + 3'h1;
          if (step == mac_tx_pkg::FCS_LAST) begin
            next_state = mac_tx_pkg::ST_DONE;
          end
        end
      end
      mac_tx_pkg::ST_ABORT: begin
        push = 1'b1;
        push_data = {2'b11, 8'h00};
        if (buf_ready) begin
          next_aborted = 1'b1;
          next_state = src_done ? mac_tx_pkg::ST_DONE : mac_tx_pkg::ST_FLUSH;
        end
      end
      mac_tx_pkg::ST_FLUSH: begin
        // Rest of an aborted frame is drained from memory
        SRC_READY = 1'b1;
        if (SRC_VALID && SRC_LAST) begin
          next_state = mac_tx_pkg::ST_DONE;
        end
      end
      mac_tx_pkg::ST_DONE: begin
        next_fcs_error = !opt_fcs && !aborted && (crc != mac_tx_pkg::CRC_RESIDUE);
        next_byte_count = count;
        finish = 1'b1;
        next_state = mac_tx_pkg::ST_IDLE;
      end
      default: begin
        next_state = mac_tx_pkg::ST_IDLE;
      end
    endcase
    // Cancel by the host ends the frame with an abort marker
    if (!req && state != mac_tx_pkg::ST_IDLE && state != mac_tx_pkg::ST_DONE &&
        state != mac_tx_pkg::ST_ABORT && state != mac_tx_pkg::ST_FLUSH) begin
      next_state = mac_tx_pkg::ST_ABORT;
      // Keep a last byte taken in this very cycle, or the drain would wait forever
      next_src_done = next_src_done || (state == mac_tx_pkg::ST_PAD) ||
                      (state == mac_tx_pkg::ST_FCS);
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= mac_tx_pkg::ST_IDLE;
      crc <= mac_tx_pkg::CRC_INIT;
      count <= 16'h0000;
      step <= 3'h0;
      src_done <= 1'b0;
      opt_fcs <= 1'b0;
      opt_oversize <= 1'b0;
      opt_pad_len <= mac_tx_pkg::PAD_NONE;
      aborted <= 1'b0;
      giant <= 1'b0;
      fcs_error <= 1'b0;
      byte_count <= 16'h0000;
    end else begin
      state <= next_state;
      crc <= next_crc;
      count <= next_count;
      step <= next_step;
      src_done <= next_src_done;
      opt_fcs <= next_opt_fcs;
      opt_oversize <= next_opt_oversize;
      opt_pad_len <= next_opt_pad_len;
      aborted <= next_aborted;
      giant <= next_giant;
      fcs_error <= next_fcs_error;
      byte_count <= next_byte_count;
    end
  end

  // ****************************************
  // Request and done flag
  // ****************************************
  always_comb begin
    next_req = req;
    next_done_flag = done_flag;
    if (TX_CANCEL || finish) begin
      next_req = 1'b0;
    end
    if (TX_REQUEST_SET && state == mac_tx_pkg::ST_IDLE) begin
      next_req = 1'b1;
    end
    if (TX_DONE_CLEAR) begin
      next_done_flag = 1'b0;
    end
    if (finish) begin
      next_done_flag = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      req <= next_req;
      done_flag <= next_done_flag;
    end
  end

  // ****************************************
  // Output buffer and ports
  // ****************************************
  tx_byte_buffer i_tx_byte_buffer (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .in_valid(push),
    .in_data(push_data),
    .in_ready(buf_ready),
    .out_valid(TX_VALID),
    .out_data(buf_out),
    .out_ready(TX_READY)
  );

  assign TX_DATA = buf_out[7:0];
  assign TX_LAST = buf_out[mac_tx_pkg::BUF_LAST];
  assign TX_ABORT = buf_out[mac_tx_pkg::BUF_ABORT];
  assign TX_REQUEST = req;
  assign TX_DONE_FLAG = done_flag;
  assign TX_ABORTED = aborted;
  assign TX_GIANT = giant;
  assign TX_FCS_ERROR = fcs_error;
  assign TX_BYTE_COUNT = byte_count;

endmodule : mac_tx_frame_assembly

`default_nettype wire

// ---- tb/mac_tx_frame_assembly_props.sv ----
// Concurrent checks on the frame assembler ports, bound into every instance.
// Assumes one clock domain with the active-low asynchronous reset.
`default_nettype none

module mac_tx_frame_assembly_props (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic TX_REQUEST_SET,
  input wire logic TX_CANCEL,
  input wire logic TX_REQUEST,
  input wire logic TX_DONE_FLAG,
  input wire logic TX_DONE_CLEAR,
  input wire logic SRC_VALID,
  input wire logic SRC_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_ABORT,
  input wire logic TX_READY,
  input wire logic TX_ABORTED,
  input wire logic TX_GIANT,
  input wire logic TX_FCS_ERROR
);
  // ****************************************
  // Handshake and framing properties
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  a_request_start: assert property ($rose(TX_REQUEST) |-> $past(TX_REQUEST_SET))
    else $error("request rose without set");
  a_done_ends: assert property ($fell(TX_REQUEST) && !$past(TX_CANCEL) |->
    $rose(TX_DONE_FLAG))
    else $error("finish without done flag");
  a_cancel_drops: assert property (TX_CANCEL && TX_REQUEST |=> !TX_REQUEST)
    else $error("cancel left request set");
  a_done_sticky: assert property (TX_DONE_FLAG && !TX_DONE_CLEAR |=> TX_DONE_FLAG)
    else $error("done flag dropped by itself");
  a_abort_marker: assert property (TX_VALID && TX_ABORT |-> TX_LAST && TX_DATA == 8'h00)
    else $error("malformed abort marker");
  a_wire_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable({TX_DATA, TX_LAST, TX_ABORT}))
    else $error("wire entry changed while stalled");
  a_status_clear: assert property ($rose(TX_REQUEST) |=>
    !TX_ABORTED && !TX_GIANT && !TX_FCS_ERROR)
    else $error("status not cleared at start");
  a_giant_aborts: assert property ($rose(TX_DONE_FLAG) && TX_GIANT |-> TX_ABORTED)
    else $error("giant frame not reported as aborted");
  a_preamble_first: assert property ($rose(TX_REQUEST) ##1 (SRC_VALID && SRC_READY) |->
    ##2 (TX_VALID && TX_DATA == 8'h55 && !TX_LAST))
    else $error("frame did not open with preamble");
endmodule : mac_tx_frame_assembly_props

bind mac_tx_frame_assembly mac_tx_frame_assembly_props i_mac_tx_frame_assembly_props (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TX_REQUEST_SET(TX_REQUEST_SET),
  .TX_CANCEL(TX_CANCEL), .TX_REQUEST(TX_REQUEST), .TX_DONE_FLAG(TX_DONE_FLAG),
  .TX_DONE_CLEAR(TX_DONE_CLEAR), .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_ABORT(TX_ABORT),
  .TX_READY(TX_READY), .TX_ABORTED(TX_ABORTED), .TX_GIANT(TX_GIANT),
  .TX_FCS_ERROR(TX_FCS_ERROR)
);

`default_nettype wire

// ---- tb/tx_src_model.sv ----
// Host memory model: control byte, then the frame bytes the host stored.
// Assumes mem and count are loaded before go; slow leaves a gap after each byte.
`default_nettype none

module tx_src_model (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] count,
  input wire logic ready,
  output logic valid,
  output logic [7:0] data,
  output logic last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] idx = 8'h00;
  logic pend = 1'b0;

  initial begin
    valid = 1'b0;
    data = 8'h00;
    last = 1'b0;
  end

  // ****************************************
  // Byte stream
  // ****************************************
  always @(posedge clk) begin
    if (go) begin
      idx <= 8'h00;
      pend <= 1'b1;
    end else if (!valid || ready) begin
      // control byte first, held until taken
      if (pend && !(valid && slow)) begin
        valid <= 1'b1;
        data <= mem[idx];
        last <= idx == count;
        idx <= idx + 8'h01;
        pend <= idx != count;
      end else begin
        valid <= 1'b0;
        data <= ~data;
        last <= 1'b0;
      end
    end
  end
endmodule : tx_src_model

`default_nettype wire

// ---- tb/tb_mac_tx_frame_assembly.sv ----
// Self-checking bench of the transmit frame assembler with a host memory model.
// Assumes the checker is bound to the design; the wire side is a stalling sink.
`default_nettype none

module tb_mac_tx_frame_assembly;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, arst_n = 1'b0, req_set = 1'b0, cancel = 1'b0, done_clr = 1'b0;
  logic gfcs = 1'b1, gover = 1'b0, go = 1'b0, slow = 1'b0, tx_ready = 1'b0;
  logic [2:0] gpad = 3'h0;
  logic [15:0] max_len = 16'h05EE;
  logic [7:0] count = 8'h00;
  logic [7:0] src_data, tx_data;
  logic src_valid, src_last, src_ready, tx_valid, tx_last, tx_abort;
  logic tx_request, done_flag, aborted, giant, fcs_err;
  logic [15:0] byte_cnt;
  logic [3:0] tick = 4'h0;
  logic [9:0] rx[$];
  int mismatches = 0;
  int checks_done = 0;

  initial forever #5 core_clk = ~core_clk;

  mac_tx_frame_assembly i_mac_tx_frame_assembly (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .TX_REQUEST_SET(req_set), .TX_CANCEL(cancel),
    .TX_REQUEST(tx_request), .TX_DONE_FLAG(done_flag), .TX_DONE_CLEAR(done_clr),
    .GLOBAL_FCS_APPEND(gfcs), .GLOBAL_OVERSIZE_ALLOW(gover), .GLOBAL_PAD_SELECT(gpad),
    .MAX_FRAME_LENGTH(max_len), .SRC_VALID(src_valid), .SRC_DATA(src_data),
    .SRC_LAST(src_last), .SRC_READY(src_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_ABORT(tx_abort), .TX_READY(tx_ready), .TX_ABORTED(aborted),
    .TX_GIANT(giant), .TX_FCS_ERROR(fcs_err), .TX_BYTE_COUNT(byte_cnt)
  );
  tx_src_model i_tx_src_model (
    .clk(core_clk), .go(go), .slow(slow), .count(count), .ready(src_ready),
    .valid(src_valid), .data(src_data), .last(src_last)
  );

  // Wire sink: four stalled cycles in sixteen fill the two-entry buffer
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) rx.push_back({tx_abort, tx_last, tx_data});
    tick <= tick + 4'h1;
    tx_ready <= tick[3:2] != 2'b00;
  end

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 32'hEDB88320 : r >> 1;
    return r;
  endfunction : crc8

  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      $display("ERROR %0t %s", $time, msg);
      mismatches++;
    end
  endtask : chk

  // ****************************************
  // One frame: load memory, request, judge the wire
  // ****************************************
  task automatic run(input logic [7:0] ctrl, input int n, input bit bad, input int cut);
    logic [9:0] exp[$];
    logic [31:0] c, h;
    logic [7:0] d;
    logic fcs, big, gnt;
    int tgt, i;
    @(posedge core_clk);
    fcs = ctrl[0] ? ctrl[1] : gfcs;
    big = ctrl[0] ? ctrl[3] : gover;
    tgt = ctrl[0] ? (ctrl[2] ? 60 : 0) : (gpad[0] ? (gpad[1] ? 64 : 60) : 0);
    gnt = !big && n > max_len;
    c = 32'hFFFFFFFF;
    h = 32'h00000000;
    i_tx_src_model.mem[0] = ctrl;
    for (i = 0; i < 8; i++) exp.push_back(i < 7 ? 10'h055 : 10'h0D5);
    for (i = 1; i <= n; i++) begin
      if (i == n - 3) h = ~c;
      d = (!fcs && i > n - 4) ? h[8 * (i - n + 3) +: 8] : i[7:0];
      d = d ^ {7'h00, bad && i == n};
      i_tx_src_model.mem[i] = d;
      c = crc8(c, d);
      if (!gnt || i <= max_len) exp.push_back({2'b00, d});
    end
    for (i = n; i < tgt && !gnt; i++) begin
      exp.push_back(10'h000);
      c = crc8(c, 8'h00);
    end
    for (i = 0; i < 4 && fcs && !gnt; i++) exp.push_back({2'b00, ~c[8 * i +: 8]});
    if (gnt) exp.push_back(10'h300);
    else exp[exp.size() - 1][8] = 1'b1;
    rx = {};
    count <= n[7:0];
    go <= 1'b1;
    req_set <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    req_set <= 1'b0;
    for (i = 0; i < 3000 && done_flag !== 1'b1; i++) begin
      @(posedge core_clk);
      req_set <= cut > 0 && i == cut - 4;
      cancel <= cut > 0 && i == cut;
      // Globals move in mid-frame; the latched options must not follow
      if (cut < 0 && i == 12) {gfcs, gover, gpad} <= ~{gfcs, gover, gpad};
    end
    if (cut < 0) {gfcs, gover, gpad} <= ~{gfcs, gover, gpad};
    if (done_flag !== 1'b1) begin
      chk(1'b0, "no completion");
      print_verdict;
    end
    repeat (12) @(posedge core_clk);
    chk(tx_request === 1'b0, "request still pending");
    chk(giant === gnt && aborted === (gnt || cut > 0), "abort status");
    if (cut <= 0) chk(fcs_err === (!fcs && !gnt && (bad || tgt > n)), "check status");
    if (cut <= 0) chk(byte_cnt === 16'(exp.size() - (gnt ? 9 : 8)), "byte count");
    if (cut <= 0) chk(rx.size() == exp.size(), "frame length");
    else chk(rx.size() > 0 && rx[rx.size() - 1] === 10'h300, "abort marker");
    for (i = 0; i < rx.size() - (cut > 0 ? 1 : 0) && i < exp.size(); i++)
      chk(rx[i] === exp[i], "wire byte");
    done_clr <= 1'b1;
    @(posedge core_clk);
    done_clr <= 1'b0;
    @(posedge core_clk);
    chk(done_flag === 1'b0, "done flag not cleared");
  endtask : run

  task automatic t_override;
    run(8'h03, 20, 1'b0, 0);
    run(8'hF3, 20, 1'b0, 0);
    run(8'h07, 20, 1'b0, 0);
    run(8'h05, 20, 1'b0, 0);
    run(8'h01, 24, 1'b0, 0);
    run(8'h01, 24, 1'b1, 0);
  endtask : t_override

  task automatic t_giant;
    max_len <= 16'h001E;
    run(8'h03, 30, 1'b0, 0);
    run(8'h03, 31, 1'b0, 0);
    run(8'h0B, 40, 1'b0, 0);
    run(8'h08, 40, 1'b0, 0);
    gover <= 1'b1;
    run(8'h00, 40, 1'b0, 0);
    max_len <= 16'h05EE;
  endtask : t_giant

  task automatic t_global;
    gpad <= 3'h3;
    run(8'h0E, 20, 1'b0, 0);
    gpad <= 3'h5;
    run(8'h0C, 20, 1'b0, 0);
    gpad <= 3'h0;
    gfcs <= 1'b0;
    run(8'h0A, 24, 1'b0, 0);
    run(8'h02, 24, 1'b1, 0);
    gfcs <= 1'b1;
  endtask : t_global

  task automatic t_cancel;
    slow <= 1'b1;
    run(8'h03, 60, 1'b0, 20);
    slow <= 1'b0;
    run(8'h07, 20, 1'b0, 0);
    run(8'h00, 20, 1'b0, -1);
  endtask : t_cancel

  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    t_override;
    t_giant;
    t_global;
    t_cancel;
    print_verdict;
  end
endmodule : tb_mac_tx_frame_assembly

`default_nettype wire
